// file: core/toeq_buf2.v
`timescale 1ns/10ps
// Two-entry buffer; a stall on the read side never loses a word
module toeq_buf2
#(
  parameter W = 36
)
(
  // Clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] slot0_r;
  reg [W-1:0] slot1_r;
  reg [1:0]   cnt_r;

  wire push;
  wire pop;

  // Ready only while a slot is free, so back-pressure reaches the source
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = slot0_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Slot0 is always the head; slot1 shifts down on pop
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slot0_r <= {W{1'b0}};
      slot1_r <= {W{1'b0}};
      cnt_r   <= 2'h0;
    end
    else
    begin
      if (pop)
      begin
        slot0_r <= (cnt_r == 2'h2) ? slot1_r : in_data;
        if (push && cnt_r == 2'h2)
          slot1_r <= in_data;
      end
      else if (push)
      begin
        if (cnt_r == 2'h0)
          slot0_r <= in_data;
        else
          slot1_r <= in_data;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // toeq_buf2

// file: core/toeq_core.v
// Overview of operation
// R1: Bits 0-2 add voltage, current, field.
// R2: Bit 3 adds trigger time hh:mm:ss.ss.
// R3: Bit 4 reserved, no effect.
// R4: Bit 5 selects formatted output.
// R5: Bit 6 sends output to serial immediately.
// R6: Bit 7 holds output for instrument-bus read.
// R7: Host writes decimal sum; query returns it.
// R8: Bus trigger or command fills enabled buffers.
// R9: Unformatted order: time, field, current, voltage.
// R10: Bad or out-of-range value gives -102.
// R11: Error beeps, queues, sets event bits.
// R12: Entry is negative code plus quoted text.
// R13: Error read returns oldest and removes it.
// R14: Ten entries; overflow marks newest as -304.
// R15: Empty queue reads as code 0.
// R16: Category flags sticky until user clears.
// R17: Parser errors -101, -103, -104.
// R18: Field units without coil constant: -106/-202.
// R19: Query during reply: replace, log -203.
// R20: Ramp start while heating: -301.
// R21: Ramp change during quench: -302.
// R22: All input buffers full: drop, -303.
// R23: Reset empties queue, flags, select register.
`timescale 1ns/10ps
`include "toeq_map.vh"
module toeq_core
(
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Decoded host commands, one-cycle strobes
  input  wire        trigger_select_write,
  input  wire        trigger_select_query,
  input  wire [15:0] cmd_value,
  input  wire        cmd_value_ok,
  input  wire        trg_cmd,
  input  wire        bus_trigger,
  input  wire        err_read,
  // Parser and system conditions, sampled with cmd_event
  input  wire        cmd_event,
  input  wire        cmd_is_query,
  input  wire        cmd_unknown,
  input  wire        cmd_non_bool,
  input  wire        cmd_missing_arg,
  input  wire        cmd_uses_field,
  input  wire        coil_const_ok,
  input  wire        reply_busy,
  input  wire        ramp_start_req,
  input  wire        heating_active,
  input  wire        ramp_change_req,
  input  wire        quench_active,
  input  wire        input_bufs_full,
  // Category flag clear (user), status enable mask
  input  wire [3:0]  cat_clr,
  input  wire [3:0]  cat_enable,
  // Measurement snapshot
  input  wire [31:0] meas_voltage,
  input  wire [31:0] meas_current,
  input  wire [31:0] meas_field,
  input  wire [31:0] meas_time_bcd,
  // Select register read-back
  output reg         qry_valid,
  output reg  [7:0]  qry_value,
  output wire [7:0]  trigger_output_select,
  // Serial transmit stream
  output wire        ser_valid,
  input  wire        ser_ready,
  output wire [35:0] ser_data,
  // Instrument-bus output stream
  output wire        gpib_valid,
  input  wire        gpib_ready,
  output wire [35:0] gpib_data,
  // Error side
  output reg         beep,
  output reg         reply_discard,
  output reg         cmd_drop,
  output reg         err_rd_valid,
  output reg         err_rd_neg,
  output reg  [9:0]  err_rd_code,
  output wire [6:0]  err_text_max,
  output wire [3:0]  cat_flags,
  output wire        cat_summary,
  output wire        err_avail,
  output wire [3:0]  err_count
);

  localparam ST_IDLE = 2'b01;
  localparam ST_EMIT = 2'b10;

  reg [7:0]  sel_r;
  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg [3:0]  items_r;
  reg [1:0]  dst_r;
  reg        fmt_r;
  reg [31:0] snap_v_r;
  reg [31:0] snap_c_r;
  reg [31:0] snap_f_r;
  reg [31:0] snap_t_r;
  reg [9:0]  q_mem [0:9];
  reg [3:0]  rd_ptr_r;
  reg [3:0]  wr_ptr_r;
  reg [3:0]  cnt_r;
  reg        ovf_r;
  reg [3:0]  cat_r;
  reg [9:0]  err_code;
  reg        err_hit;
  reg [31:0] item_data;

  wire [1:0]  cur_item;
  wire        cur_last;
  wire        ser_in_ready;
  wire        gpib_in_ready;
  wire        emit_ok;
  wire        stream_valid;
  wire [35:0] stream_word;
  wire        trig;
  wire        sel_bad;
  wire        pop;
  wire        push;
  wire        q_full;

  // Highest pending item in output order: time, field, current, voltage
  function [1:0] pick_item;
    input [3:0] m;
    begin
      if (m[`TOEQ_SEL_TIME])
        pick_item = `TOEQ_ITEM_TIME;
      else if (m[`TOEQ_SEL_FIELD])
        pick_item = `TOEQ_ITEM_FIELD;
      else if (m[`TOEQ_SEL_CURR])
        pick_item = `TOEQ_ITEM_CURR;
      else
        pick_item = `TOEQ_ITEM_VOLT;
    end
  endfunction

  // Category from code hundreds
  function [3:0] cat_of;
    input [9:0] c;
    begin
      if (c >= `TOEQ_CAT_DEV_LO)
        cat_of = 4'h1 << `TOEQ_CAT_DEV;
      else if (c >= `TOEQ_CAT_EXE_LO)
        cat_of = 4'h1 << `TOEQ_CAT_EXE;
      else if (c >= `TOEQ_CAT_QRY_LO)
        cat_of = 4'h1 << `TOEQ_CAT_QRY;
      else
        cat_of = 4'h1 << `TOEQ_CAT_CMD;
    end
  endfunction

  // Queue index wrap
  function [3:0] nxt_ptr;
    input [3:0] p;
    begin
      nxt_ptr = (p == `TOEQ_Q_LAST) ? 4'h0 : p + 4'h1;
    end
  endfunction

  assign trigger_output_select = sel_r;
  assign trig                  = trg_cmd | bus_trigger;
  // R10: range and form check
  assign sel_bad               = !cmd_value_ok || (cmd_value > `TOEQ_SEL_MAX);

  // Select register write and query read-back
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // R23: nothing enabled
      sel_r     <= `TOEQ_SEL_RESET;
      qry_valid <= 1'b0;
      qry_value <= 8'h00;
    end
    else
    begin
      // R7: store decimal sum
      // R10: bad value leaves register unchanged
      if (trigger_select_write && !sel_bad)
        sel_r <= cmd_value[7:0];
      qry_valid <= trigger_select_query;
      // R7: query returns last value written
      if (trigger_select_query)
        qry_value <= sel_r;
    end
  end

  // Emit proceeds only when every enabled destination can take the word
  // R8: both buffers may receive the same trigger
  assign emit_ok      = (!dst_r[0] || ser_in_ready) && (!dst_r[1] || gpib_in_ready);
  assign stream_valid = (state_r == ST_EMIT) && emit_ok;
  assign cur_item     = pick_item(items_r);
  // R9: last when only one enabled item remains
  assign cur_last     = (items_r & (items_r - 4'h1)) == 4'h0;

  // Item payload select
  always @*
  begin
    case (cur_item)
      `TOEQ_ITEM_TIME:
        item_data = snap_t_r;
      `TOEQ_ITEM_FIELD:
        item_data = snap_f_r;
      `TOEQ_ITEM_CURR:
        item_data = snap_c_r;
      default:
        item_data = snap_v_r;
    endcase
  end

  // R4: formatted flag travels with each word
  assign stream_word = {fmt_r, cur_last, cur_item, item_data};

  // Trigger sequencer next state
  always @*
  begin
    case (state_r)
      ST_IDLE:
        state_nxt = (trig && (sel_r[`TOEQ_SEL_TIME:`TOEQ_SEL_VOLT] != 4'h0)
                     && (sel_r[`TOEQ_SEL_GPIB:`TOEQ_SEL_SERIAL] != 2'h0))
                    ? ST_EMIT : ST_IDLE;
      ST_EMIT:
        state_nxt = (stream_valid && cur_last) ? ST_IDLE : ST_EMIT;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Snapshot on trigger; a trigger during emission is ignored
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r  <= ST_IDLE;
      items_r  <= 4'h0;
      dst_r    <= 2'h0;
      fmt_r    <= 1'b0;
      snap_v_r <= 32'h0000_0000;
      snap_c_r <= 32'h0000_0000;
      snap_f_r <= 32'h0000_0000;
      snap_t_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && trig)
      begin
        // R1: voltage, current, field items
        // R2: time item as BCD hh:mm:ss.ss
        // R3: reserved bit not copied
        items_r  <= sel_r[`TOEQ_SEL_TIME:`TOEQ_SEL_VOLT];
        fmt_r    <= sel_r[`TOEQ_SEL_FMT];
        dst_r    <= sel_r[`TOEQ_SEL_GPIB:`TOEQ_SEL_SERIAL];
        snap_v_r <= meas_voltage;
        snap_c_r <= meas_current;
        snap_f_r <= meas_field;
        snap_t_r <= meas_time_bcd;
      end
      else if (stream_valid)
        items_r <= items_r & ~(4'h1 << cur_item);
    end
  end

  // R5: serial path drains as soon as the link takes words
  toeq_buf2 #(.W(`TOEQ_SW_W)) u_ser_buf
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (stream_valid & dst_r[0]),
    .in_ready  (ser_in_ready),
    .in_data   (stream_word),
    .out_valid (ser_valid),
    .out_ready (ser_ready),
    .out_data  (ser_data)
  );

  // R6: held until the host reads it out
  toeq_buf2 #(.W(`TOEQ_SW_W)) u_gpib_buf
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (stream_valid & dst_r[1]),
    .in_ready  (gpib_in_ready),
    .in_data   (stream_word),
    .out_valid (gpib_valid),
    .out_ready (gpib_ready),
    .out_data  (gpib_data)
  );

  // Error source priority: one code per cycle
  always @*
  begin
    err_hit  = 1'b1;
    err_code = `TOEQ_ERR_NONE;
    // R22: input overflow
    if (cmd_event && input_bufs_full)
      err_code = `TOEQ_ERR_IN_OVF;
    // R17: parser errors, plus R10 bad select value
    else if (cmd_event && cmd_unknown)
      err_code = `TOEQ_ERR_UNK_CMD;
    else if (trigger_select_write && sel_bad)
      err_code = `TOEQ_ERR_BAD_ARG;
    else if (cmd_event && cmd_non_bool)
      err_code = `TOEQ_ERR_NON_BOOL;
    else if (cmd_event && cmd_missing_arg)
      err_code = `TOEQ_ERR_MISSING;
    // R18: field units need a coil constant
    else if (cmd_event && cmd_uses_field && !coil_const_ok)
      err_code = cmd_is_query ? `TOEQ_ERR_COIL_QRY : `TOEQ_ERR_COIL_CMD;
    // R21: quench blocks ramp state changes
    else if (cmd_event && ramp_change_req && quench_active)
      err_code = `TOEQ_ERR_QUENCH;
    // R20: heating period blocks ramp start
    else if (cmd_event && ramp_start_req && heating_active)
      err_code = `TOEQ_ERR_HEATING;
    // R19: new query interrupts a reply in flight
    else if (cmd_event && cmd_is_query && reply_busy)
      err_code = `TOEQ_ERR_QRY_INT;
    else
      err_hit = 1'b0;
  end

  // R13: read removes the oldest entry
  assign pop    = err_read && (cnt_r != 4'h0);
  assign q_full = (cnt_r == `TOEQ_Q_DEPTH) && !pop;
  // R14: no store while full
  assign push   = err_hit && !q_full;

  // Error queue, overflow marker and read port
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // R23: empty queue
      rd_ptr_r     <= 4'h0;
      wr_ptr_r     <= 4'h0;
      cnt_r        <= 4'h0;
      ovf_r        <= 1'b0;
      err_rd_valid <= 1'b0;
      err_rd_neg   <= 1'b0;
      err_rd_code  <= `TOEQ_ERR_NONE;
    end
    else
    begin
      err_rd_valid <= err_read;
      if (err_read)
      begin
        // R15: empty reads as code 0
        // R12: nonzero codes report negative
        err_rd_code <= pop ? q_mem[rd_ptr_r] : `TOEQ_ERR_NONE;
        err_rd_neg  <= pop;
      end
      if (pop)
      begin
        rd_ptr_r <= nxt_ptr(rd_ptr_r);
        ovf_r    <= 1'b0;
      end
      if (push)
      begin
        q_mem[wr_ptr_r] <= err_code;
        wr_ptr_r        <= nxt_ptr(wr_ptr_r);
      end
      else if (err_hit && !ovf_r)
      begin
        // R14: newest slot becomes overflow marker
        q_mem[(wr_ptr_r == 4'h0) ? `TOEQ_Q_LAST : wr_ptr_r - 4'h1] <= `TOEQ_ERR_Q_OVF;
        ovf_r <= 1'b1;
      end
      cnt_r <= cnt_r + {3'h0, push} - {3'h0, pop};
    end
  end

  // Side effects of any error, and sticky category flags
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      // R23: flags clear
      cat_r         <= 4'h0;
      beep          <= 1'b0;
      reply_discard <= 1'b0;
      cmd_drop      <= 1'b0;
    end
    else
    begin
      // R11: beep on every error
      beep          <= err_hit;
      // R19: discard unsent reply remainder
      reply_discard <= cmd_event && cmd_is_query && reply_busy;
      // R22: arriving command lost
      cmd_drop      <= cmd_event && input_bufs_full;
      // R16: set wins over user clear
      cat_r <= (cat_r & ~cat_clr) | (err_hit ? cat_of(err_code) : 4'h0);
    end
  end

  // R11: summary bit gated by user enables
  assign cat_flags    = cat_r;
  assign cat_summary  = |(cat_r & cat_enable);
  assign err_avail    = (cnt_r != 4'h0);
  assign err_count    = cnt_r;
  // R12: text length bound for the message formatter
  assign err_text_max = `TOEQ_ERR_TEXT_MAX;

endmodule // toeq_core

// file: core/toeq_map.vh
`ifndef TOEQ_MAP_VH
`define TOEQ_MAP_VH

// Trigger-select bit positions (weights 1,2,4,8,16,32,64,128)
`define TOEQ_SEL_VOLT      0
`define TOEQ_SEL_CURR      1
`define TOEQ_SEL_FIELD     2
`define TOEQ_SEL_TIME      3
`define TOEQ_SEL_RSVD      4
`define TOEQ_SEL_FMT       5
`define TOEQ_SEL_SERIAL    6
`define TOEQ_SEL_GPIB      7
`define TOEQ_SEL_RESET     8'h00
`define TOEQ_SEL_MAX       16'h00ff

// Item codes carried in the trigger stream
`define TOEQ_ITEM_TIME     2'h3
`define TOEQ_ITEM_FIELD    2'h2
`define TOEQ_ITEM_CURR     2'h1
`define TOEQ_ITEM_VOLT     2'h0

// Stream word layout: {fmt, last, item[1:0], data[31:0]}
`define TOEQ_SW_W          36
`define TOEQ_SW_FMT        35
`define TOEQ_SW_LAST       34

// Error code magnitudes (reported as negative)
`define TOEQ_ERR_NONE      10'h000
`define TOEQ_ERR_UNK_CMD   10'h065
`define TOEQ_ERR_BAD_ARG   10'h066
`define TOEQ_ERR_NON_BOOL  10'h067
`define TOEQ_ERR_MISSING   10'h068
`define TOEQ_ERR_COIL_CMD  10'h06a
`define TOEQ_ERR_COIL_QRY  10'h0ca
`define TOEQ_ERR_QRY_INT   10'h0cb
`define TOEQ_ERR_HEATING   10'h12d
`define TOEQ_ERR_QUENCH    10'h12e
`define TOEQ_ERR_IN_OVF    10'h12f
`define TOEQ_ERR_Q_OVF     10'h130
`define TOEQ_ERR_TEXT_MAX  7'h50

// Category thresholds (hundreds)
`define TOEQ_CAT_QRY_LO    10'h0c8
`define TOEQ_CAT_EXE_LO    10'h12c
`define TOEQ_CAT_DEV_LO    10'h190

// Category flag positions
`define TOEQ_CAT_CMD       0
`define TOEQ_CAT_QRY       1
`define TOEQ_CAT_EXE       2
`define TOEQ_CAT_DEV       3

// Error queue geometry
`define TOEQ_Q_DEPTH       4'ha
`define TOEQ_Q_LAST        4'h9

`endif

// file: sim/toeq_core_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module toeq_core_bench;
  logic clk = 1'b0, sys_rst = 1'b1, slow = 1'b0;
  logic trigger_select_write = 0, trigger_select_query = 0, cmd_value_ok = 0;
  logic trg_cmd = 0, bus_trigger = 0, err_read = 0, cmd_event = 0, coil_const_ok = 0;
  logic cmd_is_query = 0, cmd_unknown = 0, cmd_non_bool = 0, cmd_missing_arg = 0;
  logic cmd_uses_field = 0, reply_busy = 0, ramp_start_req = 0, heating_active = 0;
  logic ramp_change_req = 0, quench_active = 0, input_bufs_full = 0;
  logic [15:0] cmd_value = 16'h0000;
  logic [3:0] cat_clr = 4'h0, cat_enable = 4'hf;
  logic [31:0] m [4] = '{32'h0000_0a01, 32'h0000_0b02, 32'h0000_0c03, 32'h1234_5678};
  wire [31:0] meas_voltage = m[0], meas_current = m[1], meas_field = m[2];
  wire [31:0] meas_time_bcd = m[3];
  wire qry_valid, ser_valid, gpib_valid, ser_ready, gpib_ready, beep, reply_discard;
  wire cmd_drop, err_rd_valid, err_rd_neg, cat_summary, err_avail;
  wire [7:0] qry_value, trigger_output_select;
  wire [35:0] ser_data, gpib_data;
  wire [9:0] err_rd_code;
  wire [6:0] err_text_max;
  wire [3:0] cat_flags, err_count;
  logic [10:0] ef [9] = '{11'h200, 11'h100, 11'h080, 11'h040, 11'h440, 11'h420,
                          11'h018, 11'h006, 11'h001};
  logic [9:0] rq [10] = '{10'h066, 10'h066, 10'h065, 10'h067, 10'h068, 10'h06a,
                          10'h0ca, 10'h0cb, 10'h12d, 10'h130};
  int errors = 0, num_checks = 0;

  // Device and the two host-side collectors
  toeq_core uut (.*);
  toeq_sink s_ser (.clk(clk), .valid(ser_valid), .data(ser_data), .ready(ser_ready),
                   .slow(slow));
  toeq_sink s_gp (.clk(clk), .valid(gpib_valid), .data(gpib_data), .ready(gpib_ready),
                  .slow(slow));

  // Free-running system clock
  initial forever #10 clk = ~clk;

  task print_verdict;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Host sends the select value as one strobe
  task wr(input [15:0] v, input ok);
    @(negedge clk);
    trigger_select_write = 1;
    cmd_value = v;
    cmd_value_ok = ok;
    @(negedge clk);
    trigger_select_write = 0;
  endtask

  task qry(input [7:0] e);
    @(negedge clk);
    trigger_select_query = 1;
    @(negedge clk);
    trigger_select_query = 0;
    `CHK({qry_valid, qry_value}, {1'b1, e})
  endtask

  // One command arrives with its condition flags
  task ev(input [10:0] f);
    @(negedge clk);
    {cmd_is_query, cmd_unknown, cmd_non_bool, cmd_missing_arg, cmd_uses_field, reply_busy,
     ramp_start_req, heating_active, ramp_change_req, quench_active, input_bufs_full} = f;
    cmd_event = 1;
    @(negedge clk);
    cmd_event = 0;
  endtask

  task rd(input [9:0] e);
    @(negedge clk);
    err_read = 1;
    @(negedge clk);
    err_read = 0;
    `CHK({err_rd_valid, err_rd_neg, err_rd_code}, {1'b1, e != 10'h000, e})
  endtask

  // Trigger and compare both streams against the select bits
  task trig(input [7:0] sel, input bus);
    int cnt, k, t;
    logic [35:0] x;
    wr({8'h00, sel}, 1);
    s_ser.n = 0;
    s_gp.n = 0;
    cnt = $countones(sel[3:0]);
    @(negedge clk);
    bus_trigger = bus;
    trg_cmd = !bus;
    @(negedge clk);
    bus_trigger = 0;
    trg_cmd = 0;
    t = 0;
    while ((s_ser.n != (sel[6] ? cnt : 0) || s_gp.n != (sel[7] ? cnt : 0)) && t < 60)
    begin
      @(negedge clk);
      t++;
    end
    if (t == 60)
    begin
      errors++;
      print_verdict;
    end
    k = 0;
    for (int b = 3; b >= 0; b--)
      if (sel[b])
      begin
        x = {sel[5], k == cnt - 1, 2'(b), m[b]};
        if (sel[6]) `CHK(s_ser.w[k], x)
        if (sel[7]) `CHK(s_gp.w[k], x)
        k++;
      end
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(negedge clk);
    sys_rst = 0;
    `CHK({trigger_output_select, err_count, cat_flags}, 16'h0000)
    wr(16'h00c9, 1);
    qry(8'hc9);
    wr(16'h0100, 1);
    qry(8'hc9);
    wr(16'h0005, 0);
    qry(8'hc9);
    trig(8'h6f, 0);
    slow = 1;
    trig(8'h95, 1);
    trig(8'he9, 0);
    slow = 0;
    trig(8'h4b, 1);
    foreach (ef[i])
    begin
      ev(ef[i]);
      `CHK(cmd_drop, i == 8)
      `CHK(reply_discard, i == 5)
      `CHK(beep, 1'b1)
    end
    `CHK(err_count, 4'ha)
    `CHK(err_avail, 1'b1)
    `CHK(cat_flags, 4'h7)
    `CHK(cat_summary, 1'b1)
    `CHK(err_text_max, 7'h50)
    foreach (rq[i]) rd(rq[i]);
    rd(10'h000);
    `CHK(err_avail, 1'b0)
    // A defined coil constant lets field commands through silently
    coil_const_ok = 1;
    ev(11'h040);
    `CHK({beep, err_count}, 5'h00)
    @(negedge clk);
    cat_clr = 4'h1;
    cat_enable = 4'h8;
    @(negedge clk);
    cat_clr = 4'h0;
    `CHK(cat_flags, 4'h6)
    `CHK(cat_summary, 1'b0)
    print_verdict;
  end
endmodule // toeq_core_bench

bind toeq_core toeq_monitor chk (.*);

// file: sim/toeq_monitor.sv
`timescale 1ns/10ps
module toeq_monitor
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Host strobes
  input wire logic        trigger_select_write,
  input wire logic        trigger_select_query,
  input wire logic [15:0] cmd_value,
  input wire logic        cmd_value_ok,
  input wire logic        cmd_event,
  input wire logic        cmd_unknown,
  input wire logic        input_bufs_full,
  input wire logic        err_read,
  input wire logic [3:0]  cat_clr,
  // Device answers
  input wire logic [7:0]  trigger_output_select,
  input wire logic        qry_valid,
  input wire logic [7:0]  qry_value,
  input wire logic        ser_valid,
  input wire logic        ser_ready,
  input wire logic [35:0] ser_data,
  input wire logic        gpib_valid,
  input wire logic        gpib_ready,
  input wire logic        beep,
  input wire logic        cmd_drop,
  input wire logic        err_rd_valid,
  input wire logic        err_rd_neg,
  input wire logic [9:0]  err_rd_code,
  input wire logic [3:0]  cat_flags,
  input wire logic [3:0]  err_count
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Value fits in eight bits, so the wide compare is exact
  chk_sel_write: assert property (
    trigger_select_write && cmd_value_ok && cmd_value <= 16'h00ff
    |=> {8'h00, trigger_output_select} == $past(cmd_value)) else $error("select not loaded");
  chk_sel_keep: assert property (
    trigger_select_write && (!cmd_value_ok || cmd_value > 16'h00ff)
    |=> $stable(trigger_output_select)) else $error("bad value loaded");
  chk_qry_echo: assert property (
    trigger_select_query && !trigger_select_write
    |=> qry_valid && qry_value == $past(trigger_output_select)) else $error("query mismatch");
  chk_err_beep: assert property (
    cmd_event && cmd_unknown && !input_bufs_full |=> beep && cat_flags[0])
    else $error("no beep or flag");
  chk_in_drop: assert property (
    cmd_event && input_bufs_full |=> cmd_drop) else $error("no drop");
  chk_err_pop: assert property (
    err_read && !cmd_event && err_count != 4'h0
    |=> err_count == $past(err_count) - 4'h1 && err_rd_neg) else $error("no pop");
  chk_err_empty: assert property (
    err_read && !cmd_event && err_count == 4'h0
    |=> err_rd_valid && !err_rd_neg && err_rd_code == 10'h000) else $error("empty read");
  chk_q_bound: assert property (
    err_count <= 4'ha) else $error("queue too deep");
  chk_flag_hold: assert property (
    cat_flags[0] && !cat_clr[0] |=> cat_flags[0]) else $error("flag lost");
  chk_ser_hold: assert property (
    ser_valid && !ser_ready |=> ser_valid && $stable(ser_data)) else $error("word lost");

  // Main scenarios reached
  cover property (ser_valid && ser_ready);
  cover property (gpib_valid && !gpib_ready);
  cover property (err_rd_valid && err_rd_neg);
endmodule // toeq_monitor

// file: sim/toeq_sink.sv
`timescale 1ns/10ps
module toeq_sink
(
  // Clock
  input wire logic        clk,
  // Stream from the device
  input wire logic        valid,
  input wire logic [35:0] data,
  output logic            ready,
  // Pacing
  input wire logic        slow
);
  int          n = 0;
  logic [35:0] w [8];
  logic        ph = 1'b0;

  // Slow mode refuses every other cycle to stall the device
  assign ready = !slow || ph;

  always @(posedge clk)
  begin
    ph <= !ph;
    if (valid && ready)
    begin
      w[n] <= data;
      n <= n + 1;
    end
  end
endmodule // toeq_sink
